// ===== rtl/timer_pair_pkg.sv
// Holds the register map, field positions, reset values and modes of the
// timer pair. Assumes a 32-bit APB slave with one aligned word per register.
package timer_pair_pkg;

  localparam logic [7:0]  ADDR_A_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_A_TIMER    = 8'h04;
  localparam logic [7:0]  ADDR_B_CTRL     = 8'h08;
  localparam logic [7:0]  ADDR_B_TIMER    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h14;

  localparam int          CTRL_START_BIT  = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_OPT_BIT    = 3;
  localparam int          IRQ_A_BIT       = 0;
  localparam int          IRQ_B_BIT       = 1;

  localparam logic [15:0] CNT_ALL_ONES    = 16'hFFFF;
  localparam logic [15:0] CNT_ALL_ZEROS   = 16'h0000;
  localparam logic [15:0] CNT_RESET       = 16'h0000;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    A_TIMER   = 2'b00,
    A_EVENT   = 2'b01,
    A_ONESHOT = 2'b10,
    A_PWM     = 2'b11
  } a_mode_t;

  typedef enum logic [1:0] {
    B_TIMER   = 2'b00,
    B_EVENT   = 2'b01,
    B_MEASURE = 2'b10,
    B_SPARE   = 2'b11
  } b_mode_t;

endpackage : timer_pair_pkg

// ===== rtl/multimode_timer_pair.sv
// Two 16-bit timers, type A with an output pin and type B with an input pin,
// behind an APB slave. Assumes pins are asynchronous to i_clk_sys.
//
// Behaviour
// - Type A counting read returns live counter.
// - Timer mode reload-instant read returns all ones.
// - Event reload read: ones underflow, zeros overflow.
// - Halted write then read returns written value.
// - One-shot halt stops counter and reloads it.
// - One-shot halt drives output pin low.
// - One-shot halt sets type A request bit.
// - Selecting one-shot mode from timer/event (or first) sets request bit.
// - Selecting PWM mode from timer/event (or first) sets request bit.
// - PWM halt with high pin: low, request.
// - PWM halt with low pin: no change.
// - Type B timer/event reads live, all ones at reload.
// - Measurement select change sets type B request.
// - First measured edge loads undefined reload value.
// - First measured edge raises no request.
`timescale 1ns/100ps
module multimode_timer_pair
  import timer_pair_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_type_a_event_pin,
  input  wire logic        i_type_b_timer_input_pin,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_irq,
  output logic             o_type_a_timer_output_pin
);

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        a_start;
    a_mode_t     a_mode;
    logic        a_up;
    logic        a_seen;
    logic        a_active;
    logic        a_out;
    logic [15:0] a_reload;
    logic [15:0] a_cnt;
    logic        b_start;
    b_mode_t     b_mode;
    logic        b_sel;
    logic        b_first;
    logic [15:0] b_reload;
    logic [15:0] b_cnt;
    logic        a_s1;
    logic        a_s2;
    logic        a_s3;
    logic        b_s1;
    logic        b_s2;
    logic        b_s3;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic a_tick;
  logic a_rl;
  logic a_ovf;
  logic a_set;
  logic b_tick;
  logic b_edge;
  logic b_rl;
  logic b_set;

  always_comb begin
    state_next = state_reg;
    setup  = i_psel & ~i_penable;
    wr_acc = i_psel & i_penable & state_reg.pready & i_pwrite;
    rd_acc = i_psel & i_penable & state_reg.pready & ~i_pwrite;
    a_rl   = 1'b0;
    a_ovf  = 1'b0;
    a_set  = 1'b0;
    b_rl   = 1'b0;
    b_set  = 1'b0;
    state_next.a_s1 = i_type_a_event_pin;
    state_next.a_s2 = state_reg.a_s1;
    state_next.a_s3 = state_reg.a_s2;
    state_next.b_s1 = i_type_b_timer_input_pin;
    state_next.b_s2 = state_reg.b_s1;
    state_next.b_s3 = state_reg.b_s2;
    a_tick = (state_reg.a_mode == A_EVENT) ?
             (state_reg.a_s2 & ~state_reg.a_s3) : 1'b1;
    b_edge = state_reg.b_sel ? (state_reg.b_s2 ^ state_reg.b_s3)
                             : (state_reg.b_s2 & ~state_reg.b_s3);
    b_tick = (state_reg.b_mode == B_EVENT) ?
             (state_reg.b_s2 & ~state_reg.b_s3) : 1'b1;

    // Type A counting.
    if (state_reg.a_start) begin
      case (state_reg.a_mode)
        A_TIMER: begin
          if (state_reg.a_cnt == CNT_ALL_ZEROS) begin
            state_next.a_cnt = state_reg.a_reload;
            a_rl  = 1'b1;
            a_set = 1'b1;
          end else begin
            state_next.a_cnt = state_reg.a_cnt - 16'h0001;
          end
        end
        A_EVENT: begin
          if (a_tick && state_reg.a_up) begin
            if (state_reg.a_cnt == CNT_ALL_ONES) begin
              state_next.a_cnt = state_reg.a_reload;
              a_rl  = 1'b1;
              a_ovf = 1'b1;
              a_set = 1'b1;
            end else begin
              state_next.a_cnt = state_reg.a_cnt + 16'h0001;
            end
          end else if (a_tick) begin
            if (state_reg.a_cnt == CNT_ALL_ZEROS) begin
              state_next.a_cnt = state_reg.a_reload;
              a_rl  = 1'b1;
              a_set = 1'b1;
            end else begin
              state_next.a_cnt = state_reg.a_cnt - 16'h0001;
            end
          end
        end
        A_ONESHOT: begin
          if (state_reg.a_active) begin
            if (state_reg.a_cnt == CNT_ALL_ZEROS) begin
              state_next.a_cnt    = state_reg.a_reload;
              state_next.a_active = 1'b0;
              state_next.a_out    = 1'b0;
              a_set = 1'b1;
            end else begin
              state_next.a_cnt = state_reg.a_cnt - 16'h0001;
            end
          end
        end
        A_PWM: begin
          if (state_reg.a_cnt == CNT_ALL_ZEROS) begin
            state_next.a_cnt = state_reg.a_reload;
            state_next.a_out = ~state_reg.a_out;
            a_set = state_reg.a_out;
          end else begin
            state_next.a_cnt = state_reg.a_cnt - 16'h0001;
          end
        end
        default: begin
          state_next.a_cnt = state_reg.a_cnt;
        end
      endcase
    end

    // Type B counting and measurement.
    if (state_reg.b_start) begin
      case (state_reg.b_mode)
        B_TIMER, B_EVENT: begin
          if (b_tick) begin
            if (state_reg.b_cnt == CNT_ALL_ZEROS) begin
              state_next.b_cnt = state_reg.b_reload;
              b_rl  = 1'b1;
              b_set = 1'b1;
            end else begin
              state_next.b_cnt = state_reg.b_cnt - 16'h0001;
            end
          end
        end
        B_MEASURE: begin
          if (b_edge) begin
            state_next.b_reload = state_reg.b_cnt;
            state_next.b_cnt    = CNT_ALL_ZEROS;
            state_next.b_first  = 1'b0;
            b_set = ~state_reg.b_first;
          end else begin
            state_next.b_cnt = state_reg.b_cnt + 16'h0001;
          end
        end
        default: begin
          state_next.b_cnt = state_reg.b_cnt;
        end
      endcase
    end

    // Register writes take effect at the access edge.
    if (wr_acc) begin
      case (i_paddr)
        ADDR_A_CTRL: begin
          state_next.a_start = i_pwdata[CTRL_START_BIT];
          state_next.a_mode  = a_mode_t'(i_pwdata[CTRL_MODE_LSB +: 2]);
          state_next.a_up    = i_pwdata[CTRL_OPT_BIT];
          state_next.a_seen  = 1'b1;
          if ((state_next.a_mode == A_ONESHOT ||
               state_next.a_mode == A_PWM) &&
              (!state_reg.a_seen || state_reg.a_mode == A_TIMER ||
               state_reg.a_mode == A_EVENT)) begin
            a_set = 1'b1;
          end
          if (state_reg.a_start && !state_next.a_start) begin
            state_next.a_active = 1'b0;
            if (state_reg.a_mode == A_ONESHOT && state_reg.a_active) begin
              state_next.a_cnt = state_reg.a_reload;
              state_next.a_out = 1'b0;
              a_set = 1'b1;
            end else if (state_reg.a_mode == A_PWM) begin
              state_next.a_out = 1'b0;
              a_set = a_set | state_reg.a_out;
            end else begin
              state_next.a_out = state_reg.a_out;
            end
          end
          if (!state_reg.a_start && state_next.a_start &&
              (state_next.a_mode == A_ONESHOT ||
               state_next.a_mode == A_PWM)) begin
            state_next.a_active = 1'b1;
            state_next.a_out    = 1'b1;
            state_next.a_cnt    = state_reg.a_reload;
          end
        end
        ADDR_A_TIMER: begin
          state_next.a_reload = i_pwdata[15:0];
          if (!state_reg.a_start) begin
            state_next.a_cnt = i_pwdata[15:0];
          end
        end
        ADDR_B_CTRL: begin
          state_next.b_start = i_pwdata[CTRL_START_BIT];
          state_next.b_mode  = b_mode_t'(i_pwdata[CTRL_MODE_LSB +: 2]);
          state_next.b_sel   = i_pwdata[CTRL_OPT_BIT];
          if (state_reg.b_start && state_reg.b_mode == B_MEASURE &&
              state_next.b_sel != state_reg.b_sel) begin
            b_set = 1'b1;
          end
          if (!state_reg.b_start && state_next.b_start &&
              state_next.b_mode == B_MEASURE) begin
            state_next.b_cnt   = CNT_ALL_ZEROS;
            state_next.b_first = 1'b1;
          end
        end
        ADDR_B_TIMER: begin
          state_next.b_reload = i_pwdata[15:0];
          if (!state_reg.b_start) begin
            state_next.b_cnt = i_pwdata[15:0];
          end
        end
        ADDR_IRQ_MASK: begin
          state_next.irq_mask = i_pwdata[1:0];
        end
        default: begin
          state_next.irq_mask = state_reg.irq_mask;
        end
      endcase
    end

    // Read data is sampled in the setup cycle, answered one cycle later.
    state_next.pready  = setup;
    state_next.pslverr = 1'b0;
    if (setup) begin
      state_next.prdata = WORD_ZERO;
      case (i_paddr)
        ADDR_A_CTRL: begin
          state_next.prdata[CTRL_START_BIT]     = state_reg.a_start;
          state_next.prdata[CTRL_MODE_LSB +: 2] = state_reg.a_mode;
          state_next.prdata[CTRL_OPT_BIT]       = state_reg.a_up;
        end
        ADDR_A_TIMER: begin
          state_next.prdata[15:0] = !a_rl ? state_reg.a_cnt :
                                    a_ovf ? CNT_ALL_ZEROS :
                                    CNT_ALL_ONES;
        end
        ADDR_B_CTRL: begin
          state_next.prdata[CTRL_START_BIT]     = state_reg.b_start;
          state_next.prdata[CTRL_MODE_LSB +: 2] = state_reg.b_mode;
          state_next.prdata[CTRL_OPT_BIT]       = state_reg.b_sel;
        end
        ADDR_B_TIMER: begin
          state_next.prdata[15:0] =
            (state_reg.b_mode == B_MEASURE) ? state_reg.b_reload :
            b_rl ? CNT_ALL_ONES : state_reg.b_cnt;
        end
        ADDR_IRQ_STATUS: begin
          state_next.prdata[1:0] = state_reg.irq_stat;
        end
        ADDR_IRQ_MASK: begin
          state_next.prdata[1:0] = state_reg.irq_mask;
        end
        default: begin
          state_next.pslverr = 1'b1;
        end
      endcase
    end

    // Read clears only the bits it reported; a new event wins.
    if (rd_acc && i_paddr == ADDR_IRQ_STATUS) begin
      state_next.irq_stat = state_reg.irq_stat & ~state_reg.prdata[1:0];
    end
    state_next.irq_stat[IRQ_A_BIT] = state_next.irq_stat[IRQ_A_BIT] | a_set;
    state_next.irq_stat[IRQ_B_BIT] = state_next.irq_stat[IRQ_B_BIT] | b_set;
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_reg          <= '0;
      state_reg.a_reload <= CNT_RESET;
      state_reg.a_cnt    <= CNT_RESET;
      state_reg.b_reload <= CNT_RESET;
      state_reg.b_cnt    <= CNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_pready                  = state_reg.pready;
  assign o_prdata                  = state_reg.prdata;
  assign o_pslverr                 = state_reg.pslverr;
  assign o_irq                     = state_reg.irq;
  assign o_type_a_timer_output_pin = state_reg.a_out;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_live_read_a: assert property (
    setup && i_paddr == ADDR_A_TIMER && state_reg.a_start &&
    state_reg.a_mode == A_TIMER && state_reg.a_cnt != CNT_ALL_ZEROS
    |=> o_prdata[15:0] == $past(state_reg.a_cnt))
    else $error("Type A live read wrong.");
  a_reload_ones_a: assert property (
    setup && i_paddr == ADDR_A_TIMER && state_reg.a_start &&
    state_reg.a_mode == A_TIMER && state_reg.a_cnt == CNT_ALL_ZEROS
    |=> o_prdata[15:0] == CNT_ALL_ONES)
    else $error("Timer reload read not all ones.");
  a_overflow_zero_a: assert property (
    setup && i_paddr == ADDR_A_TIMER && state_reg.a_start && a_tick &&
    state_reg.a_mode == A_EVENT && state_reg.a_up &&
    state_reg.a_cnt == CNT_ALL_ONES
    |=> o_prdata[15:0] == CNT_ALL_ZEROS)
    else $error("Overflow reload read not zero.");
  halted_write_a: assert property (
    wr_acc && i_paddr == ADDR_A_TIMER && !state_reg.a_start
    |=> state_reg.a_cnt == $past(i_pwdata[15:0]) &&
        state_reg.a_reload == $past(i_pwdata[15:0]))
    else $error("Halted write not loaded.");
  oneshot_halt_a: assert property (
    wr_acc && i_paddr == ADDR_A_CTRL && state_reg.a_start &&
    state_reg.a_active && state_reg.a_mode == A_ONESHOT &&
    !i_pwdata[CTRL_START_BIT]
    |=> !o_type_a_timer_output_pin && state_reg.irq_stat[IRQ_A_BIT] &&
        state_reg.a_cnt == $past(state_reg.a_reload))
    else $error("One-shot halt wrong.");
  pwm_high_halt_a: assert property (
    wr_acc && i_paddr == ADDR_A_CTRL && state_reg.a_start &&
    state_reg.a_mode == A_PWM && state_reg.a_out &&
    !i_pwdata[CTRL_START_BIT]
    |=> !o_type_a_timer_output_pin && state_reg.irq_stat[IRQ_A_BIT])
    else $error("PWM high halt wrong.");
  pwm_low_halt_a: assert property (
    wr_acc && i_paddr == ADDR_A_CTRL && state_reg.a_start &&
    state_reg.a_mode == A_PWM && !state_reg.a_out &&
    i_pwdata[CTRL_MODE_LSB +: 2] == A_PWM && !i_pwdata[CTRL_START_BIT]
    |=> !o_type_a_timer_output_pin && !$rose(state_reg.irq_stat[IRQ_A_BIT]))
    else $error("PWM low halt raised request.");
  mode_select_a: assert property (
    wr_acc && i_paddr == ADDR_A_CTRL && state_reg.a_mode == A_TIMER &&
    i_pwdata[CTRL_MODE_LSB +: 2] == A_ONESHOT
    |=> state_reg.irq_stat[IRQ_A_BIT])
    else $error("Mode change did not set request.");
  b_reload_ones_a: assert property (
    setup && i_paddr == ADDR_B_TIMER && state_reg.b_start &&
    state_reg.b_mode == B_TIMER && state_reg.b_cnt == CNT_ALL_ZEROS
    |=> o_prdata[15:0] == CNT_ALL_ONES)
    else $error("Type B reload read not all ones.");
  sel_change_a: assert property (
    wr_acc && i_paddr == ADDR_B_CTRL && state_reg.b_start &&
    state_reg.b_mode == B_MEASURE &&
    i_pwdata[CTRL_OPT_BIT] != state_reg.b_sel
    |=> state_reg.irq_stat[IRQ_B_BIT])
    else $error("Select change did not set request.");
  first_edge_a: assert property (
    state_reg.b_start && state_reg.b_mode == B_MEASURE && b_edge &&
    state_reg.b_first && !wr_acc
    |=> !$rose(state_reg.irq_stat[IRQ_B_BIT]))
    else $error("First edge raised request.");

  oneshot_run_c: cover property (
    state_reg.a_active ##1 !state_reg.a_active);
  pwm_toggle_c: cover property (
    state_reg.a_mode == A_PWM && $fell(o_type_a_timer_output_pin));
  measure_c: cover property (
    state_reg.b_mode == B_MEASURE && $rose(state_reg.irq_stat[IRQ_B_BIT]));
  irq_c: cover property ($rose(o_irq));

endmodule : multimode_timer_pair

// ===== verification/timer_pin_partner.sv
// Pin model outside the timer pair: drives event and input pulses.
// Assumes its tasks are called from a process synchronous to the clock.
`timescale 1ns/100ps
module timer_pin_partner (
  input  wire logic i_clk_sys,
  output logic      o_a_event,
  output logic      o_b_in
);
  initial begin
    o_a_event = 1'b0;
    o_b_in    = 1'b0;
  end

  task automatic set_pin(input logic sel, input logic v);
    if (sel) begin
      o_b_in <= v;
    end else begin
      o_a_event <= v;
    end
  endtask : set_pin

  // Pulses stay well above the two-cycle minimum that the sync flops need.
  task automatic pulse(input logic sel, input int n);
    repeat (n) begin
      set_pin(sel, 1'b1);
      repeat (8) @(posedge i_clk_sys);
      set_pin(sel, 1'b0);
      repeat (8) @(posedge i_clk_sys);
    end
  endtask : pulse
endmodule : timer_pin_partner

// ===== verification/test_multimode_timer_pair.sv
// Self-checking bench for the timer pair over APB with a pin model.
// Assumes zero-wait APB answers and registered outputs as the notes state.
`timescale 1ns/100ps
module test_multimode_timer_pair;
  import timer_pair_pkg::*;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] care;
    logic        err;
  } note_t;
  localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
  localparam logic [31:0] BIT_A = 32'h0000_0001;
  localparam logic [31:0] BIT_B = 32'h0000_0002;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        a_ev;
  logic        b_in;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic        a_pin;
  logic [31:0] rd;
  logic [31:0] v;
  note_t       cur;
  note_t       notes[$];
  int          mismatches = 0;
  int          compares   = 0;
  integer      seed       = 32'h0123_77e6;

  always #4 clk_sys = ~clk_sys;

  multimode_timer_pair i_dut (
    .i_clk_sys                (clk_sys),
    .i_sys_rst                (sys_rst),
    .i_psel                   (psel),
    .i_penable                (penable),
    .i_pwrite                 (pwrite),
    .i_paddr                  (paddr),
    .i_pwdata                 (pwdata),
    .i_type_a_event_pin       (a_ev),
    .i_type_b_timer_input_pin (b_in),
    .o_pready                 (pready),
    .o_prdata                 (prdata),
    .o_pslverr                (pslverr),
    .o_irq                    (irq),
    .o_type_a_timer_output_pin(a_pin)
  );

  timer_pin_partner i_pins (
    .i_clk_sys(clk_sys),
    .o_a_event(a_ev),
    .o_b_in   (b_in)
  );

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : check_bit

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Takes the oldest note at each completed transfer and compares it.
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check_bit(1'b0, 1'b1, "transfer without a note");
      end else begin
        cur = notes.pop_front();
        check_bit(pslverr, cur.err, "slave error");
        check_word(prdata & cur.care, cur.exp & cur.care, "read data");
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] c);
    int n;
    n = 0;
    notes.push_back('{e, w ? 32'h0000_0000 : c, a > ADDR_IRQ_MASK});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic st,
                                      input logic op);
    return {28'h000_0000, op, m, st};
  endfunction : ctl

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask : do_reset

  task automatic wait_pin(input logic lv);
    int n;
    n = 0;
    while (a_pin !== lv && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    check_bit(a_pin, lv, "pin level wait");
  endtask : wait_pin

  // Back-to-back reads every third cycle cover every phase of a 4-cycle loop.
  task automatic sweep(input logic [7:0] a);
    logic ones;
    logic mid;
    ones = 1'b0;
    mid  = 1'b0;
    repeat (12) begin
      apb(1'b0, a, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      ones = ones | (rd[15:0] === CNT_ALL_ONES);
      mid  = mid | (rd[15:0] === 16'h0002) | (rd[15:0] === 16'h0001);
      check_bit(rd[15:0] <= 16'h0003 || rd[15:0] === CNT_ALL_ONES, 1'b1,
                "count range");
    end
    check_bit(ones, 1'b1, "all ones at reload");
    check_bit(mid, 1'b1, "live count seen");
  endtask : sweep

  initial begin
    #(8 * 20000);
    mismatches++;
    final_report;
  end

  initial begin
    do_reset;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000, WORD_ZERO, ALL);
    end
    apb(1'b1, 8'h18, ALL, 32'h0000_0000, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000, WORD_ZERO, ALL);
    check_bit(irq | a_pin, 1'b0, "outputs after reset");
    $display("Test reset and map done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, i[0] ? ADDR_B_TIMER : ADDR_A_TIMER, v, 32'h0000_0000,
          32'h0000_0000);
      apb(1'b0, i[0] ? ADDR_B_TIMER : ADDR_A_TIMER, 32'h0000_0000,
          {16'h0000, v[15:0]}, ALL);
    end
    $display("Test halted write done");
    apb(1'b1, ADDR_A_CTRL, ctl(A_ONESHOT, 1'b0, 1'b0), 0, 0);
    apb(1'b0, ADDR_IRQ_STATUS, 0, BIT_A, ALL);
    apb(1'b0, ADDR_IRQ_STATUS, 0, 0, ALL);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_A_CTRL, ctl(i[0] ? A_EVENT : A_TIMER, 1'b0, 1'b0), 0, 0);
      apb(1'b0, ADDR_IRQ_STATUS, 0, 0, 0);
      apb(1'b1, ADDR_A_CTRL, ctl(i[1] ? A_PWM : A_ONESHOT, 1'b0, 1'b0), 0, 0);
      apb(1'b0, ADDR_IRQ_STATUS, 0, BIT_A, BIT_A);
    end
    do_reset;
    apb(1'b1, ADDR_A_CTRL, ctl(A_PWM, 1'b0, 1'b0), 0, 0);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b0, "masked request");
    apb(1'b1, ADDR_IRQ_MASK, BIT_A, 0, 0);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b1, "unmasked request");
    apb(1'b0, ADDR_IRQ_STATUS, 0, BIT_A, ALL);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b0, "request cleared");
    $display("Test mode select requests done");
    apb(1'b1, ADDR_A_CTRL, ctl(A_ONESHOT, 1'b0, 1'b0), 0, 0);
    apb(1'b1, ADDR_A_TIMER, 32'h0000_0100, 0, 0);
    apb(1'b1, ADDR_A_CTRL, ctl(A_ONESHOT, 1'b1, 1'b0), 0, 0);
    apb(1'b0, ADDR_IRQ_STATUS, 0, 0, 0);
    check_bit(a_pin, 1'b1, "one-shot running");
    apb(1'b1, ADDR_A_CTRL, ctl(A_ONESHOT, 1'b0, 1'b0), 0, 0);
    repeat (3) @(posedge clk_sys);
    check_bit(a_pin, 1'b0, "one-shot halted pin");
    apb(1'b0, ADDR_A_TIMER, 0, 32'h0000_0100, ALL);
    apb(1'b0, ADDR_IRQ_STATUS, 0, BIT_A, BIT_A);
    $display("Test one-shot halt done");
    apb(1'b1, ADDR_A_TIMER, 32'h0000_0020, 0, 0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_A_CTRL, ctl(A_PWM, 1'b1, 1'b0), 0, 0);
      wait_pin(1'b1);
      if (i == 1) begin
        wait_pin(1'b0);
      end
      apb(1'b0, ADDR_IRQ_STATUS, 0, 0, 0);
      apb(1'b1, ADDR_A_CTRL, ctl(A_PWM, 1'b0, 1'b0), 0, 0);
      repeat (3) @(posedge clk_sys);
      check_bit(a_pin, 1'b0, "pwm halted pin");
      apb(1'b0, ADDR_IRQ_STATUS, 0, i == 0 ? BIT_A : 0, BIT_A);
    end
    $display("Test pwm halt done");
    apb(1'b1, ADDR_A_CTRL, ctl(A_EVENT, 1'b0, 1'b0), 0, 0);
    apb(1'b1, ADDR_A_TIMER, 32'h0000_0005, 0, 0);
    apb(1'b1, ADDR_A_CTRL, ctl(A_EVENT, 1'b1, 1'b0), 0, 0);
    i_pins.pulse(1'b0, 2);
    apb(1'b0, ADDR_A_TIMER, 0, 32'h0000_0003, ALL);
    apb(1'b1, ADDR_A_CTRL, ctl(A_EVENT, 1'b0, 1'b0), 0, 0);
    apb(1'b1, ADDR_A_TIMER, 32'h0000_0005, 0, 0);
    apb(1'b0, ADDR_A_TIMER, 0, 32'h0000_0005, ALL);
    // The read's setup edge meets the third edge after the pin rises.
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_A_TIMER, i[0] ? 32'h0000_0000 : 32'h0000_FFFF, 0, 0);
      apb(1'b1, ADDR_A_CTRL, ctl(A_EVENT, 1'b1, ~i[0]), 0, 0);
      i_pins.set_pin(1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      apb(1'b0, ADDR_A_TIMER, 0, i[0] ? {16'h0000, CNT_ALL_ONES} :
          {16'h0000, CNT_ALL_ZEROS}, ALL);
      i_pins.set_pin(1'b0, 1'b0);
      apb(1'b1, ADDR_A_CTRL, ctl(A_EVENT, 1'b0, 1'b0), 0, 0);
    end
    $display("Test event counter done");
    apb(1'b1, ADDR_A_CTRL, ctl(A_TIMER, 1'b0, 1'b0), 0, 0);
    apb(1'b1, ADDR_A_TIMER, 32'h0000_0003, 0, 0);
    apb(1'b1, ADDR_A_CTRL, ctl(A_TIMER, 1'b1, 1'b0), 0, 0);
    sweep(ADDR_A_TIMER);
    apb(1'b1, ADDR_B_TIMER, 32'h0000_0003, 0, 0);
    apb(1'b1, ADDR_B_CTRL, ctl(B_TIMER, 1'b1, 1'b0), 0, 0);
    sweep(ADDR_B_TIMER);
    $display("Test live reads done");
    apb(1'b1, ADDR_B_CTRL, ctl(B_EVENT, 1'b0, 1'b0), 0, 0);
    apb(1'b1, ADDR_B_TIMER, 32'h0000_0005, 0, 0);
    apb(1'b1, ADDR_B_CTRL, ctl(B_EVENT, 1'b1, 1'b0), 0, 0);
    i_pins.pulse(1'b1, 2);
    apb(1'b0, ADDR_B_TIMER, 0, 32'h0000_0003, ALL);
    apb(1'b1, ADDR_B_CTRL, ctl(B_MEASURE, 1'b0, 1'b0), 0, 0);
    apb(1'b1, ADDR_B_CTRL, ctl(B_MEASURE, 1'b1, 1'b0), 0, 0);
    apb(1'b0, ADDR_IRQ_STATUS, 0, 0, 0);
    i_pins.pulse(1'b1, 1);
    apb(1'b0, ADDR_IRQ_STATUS, 0, 0, BIT_B);
    apb(1'b1, ADDR_B_CTRL, ctl(B_MEASURE, 1'b1, 1'b1), 0, 0);
    apb(1'b0, ADDR_IRQ_STATUS, 0, BIT_B, BIT_B);
    $display("Test measurement done");
    final_report;
  end
endmodule : test_multimode_timer_pair
